// *** common/scil_pkg.sv ***
// Constants shared by the servo control input logic.
// Assumes a 125 MHz system clock and an AXI4-Lite register slave.
package scil_pkg;
	// Clock and debounce timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEBOUNCE_NS = 1000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Register map, byte addresses
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 6'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 6'h04;
	localparam logic [ADDR_W-1:0] SPEED1_OFS = 6'h08;
	localparam logic [ADDR_W-1:0] SPEED2_OFS = 6'h0c;
	localparam logic [ADDR_W-1:0] SPEED3_OFS = 6'h10;
	localparam logic [ADDR_W-1:0] SPEED4_OFS = 6'h14;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 6'h18;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 6'h1c;
	// Control register fields
	localparam int CTRL_W = 2;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_STOP_MASK_BIT = 1;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
	// Internal speed values
	localparam int SPEED_W = 16;
	localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;
	// Alarms
	localparam int ALARM_CODE_W = 5;
	localparam logic [ALARM_CODE_W-1:0] ALARM_CLEARABLE_MAX = 5'h08;
	// Input vector positions after debouncing
	localparam int IN_W = 6;
	localparam int IN_SON = 0;
	localparam int IN_ALARM_CLEAR_IN = 1;
	localparam int IN_CCW = 2;
	localparam int IN_CW = 3;
	localparam int IN_SEL0 = 4;
	localparam int IN_INH = 5;
	// Interrupt events
	localparam int EV_W = 5;
	localparam int EV_ALARM = 0;
	localparam int EV_ENABLE = 1;
	localparam int EV_CCW_STOP = 2;
	localparam int EV_CW_STOP = 3;
	localparam int EV_DEV_CLEAR = 4;
	localparam logic [EV_W-1:0] EV_RST = 5'h00;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control modes
	typedef enum logic {SCIL_MODE_POS = 1'b0, SCIL_MODE_SPD = 1'b1} scil_mode_t;
endpackage

// *** verilog/scil_debounce.sv ***
// Two-flop synchroniser and debounce filter for a group of isolated inputs.
// Assumes inputs are level signals asynchronous to clk.
`timescale 1ns/10ps
module scil_debounce #(
	parameter int W = 6,
	parameter int CYC = 125
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] clean_ff
);
	import scil_pkg::*;
	localparam int CW = $clog2(CYC + 1);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [CW-1:0] cnt_ff [W];

	if (W < 1 || CYC < 1) begin : g_chk
		$error("scil_debounce: W and CYC must be at least 1");
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= raw;
			sync_ff <= meta_ff;
		end
	end

	// Output follows only after the synced level has differed for CYC cycles
	always_ff @(posedge clk) begin
		for (int i = 0; i < W; i++) begin
			if (!rst_n) begin
				cnt_ff[i] <= '0;
				clean_ff[i] <= 1'b0;
			end else if (sync_ff[i] == clean_ff[i]) begin
				cnt_ff[i] <= '0;
			end else if (cnt_ff[i] == CW'(CYC - 1)) begin
				cnt_ff[i] <= '0;
				clean_ff[i] <= sync_ff[i];
			end else begin
				cnt_ff[i] <= cnt_ff[i] + 1'b1;
			end
		end
	end

	for (genvar g = 0; g < W; g++) begin : g_chk_bit
		debounce_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
			$changed(clean_ff[g]) |-> $past(cnt_ff[g]) == CW'(CYC - 1))
			else $error("debounced input changed before its hold time");
	end
endmodule

// *** verilog/scil_speed_sel.sv ***
// Picks one of four programmable internal speeds from a two-bit select.
// Assumes select and speed values are synchronous to clk.
`timescale 1ns/10ps
module scil_speed_sel #(
	parameter int SW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [1:0] sel,
	input wire logic [SW-1:0] speed1,
	input wire logic [SW-1:0] speed2,
	input wire logic [SW-1:0] speed3,
	input wire logic [SW-1:0] speed4,
	output logic [SW-1:0] speed_cmd_ff
);
	import scil_pkg::*;

	function automatic logic [SW-1:0] pick(input logic [1:0] s, input logic [SW-1:0] a, input logic [SW-1:0] b,
			input logic [SW-1:0] c, input logic [SW-1:0] d);
		unique case (s)
			2'h0: pick = a;
			2'h1: pick = b;
			2'h2: pick = c;
			2'h3: pick = d;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			speed_cmd_ff <= '0;
		end else if (en) begin
			speed_cmd_ff <= pick(sel, speed1, speed2, speed3, speed4);
		end else begin
			speed_cmd_ff <= '0;
		end
	end
endmodule

// *** verilog/scil_top.sv ***
// Servo control input logic: decodes the isolated control inputs per mode.
// Assumes one 125 MHz clock, an AXI4-Lite master and a fault source in the drive.
`timescale 1ns/10ps
// Overview of operation
// - Servo enable on enables the drive while no alarm is latched; off disables it, motor free.
// - Alarm clear on clears the latched alarm; off keeps it.
// - Alarm codes above 8 stay latched until aresetn resets the logic.
// - CCW stop off blocks CCW drive and holds CCW torque at zero.
// - CW stop off blocks CW drive and holds CW torque at zero.
// - A configuration bit masks both directional stop inputs.
// - In position mode deviation clear zeroes the deviation counter.
// - In speed mode two select bits choose internal speed one to four.
// - The four internal speeds come from writable registers.
// - Position and speed modes; mode inputs act only in their mode.
// - In position mode pulse inhibit on blocks command pulses.
module scil_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [scil_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [scil_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic servo_enable_in,
	input wire logic alarm_clear_in,
	input wire logic ccw_stop_n,
	input wire logic cw_stop_n,
	input wire logic speed_sel0,
	input wire logic pulse_inhibit_in,
	input wire logic fault_valid,
	input wire logic [scil_pkg::ALARM_CODE_W-1:0] fault_code,
	output logic drive_enable_ff,
	output logic ccw_permit_ff,
	output logic cw_permit_ff,
	output logic dev_clear_ff,
	output logic pulse_accept_ff,
	output logic speed_valid_ff,
	output logic [scil_pkg::SPEED_W-1:0] speed_cmd,
	output logic alarm_ff,
	output logic [scil_pkg::ALARM_CODE_W-1:0] alarm_code_ff,
	output logic irq
);
	import scil_pkg::*;

	typedef enum logic [1:0] {SCIL_WS_IDLE = 2'b01, SCIL_WS_RESP = 2'b10} scil_wstate_t;
	typedef enum logic [1:0] {SCIL_RS_IDLE = 2'b01, SCIL_RS_DATA = 2'b10} scil_rstate_t;

	logic [IN_W-1:0] in_ff;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [SPEED_W-1:0] speed1_ff;
	logic [SPEED_W-1:0] speed2_ff;
	logic [SPEED_W-1:0] speed3_ff;
	logic [SPEED_W-1:0] speed4_ff;
	logic [EV_W-1:0] irq_status_ff;
	logic [EV_W-1:0] irq_mask_ff;
	logic [EV_W-1:0] ev_now;
	scil_wstate_t wstate_ff;
	scil_rstate_t rstate_ff;
	logic aw_have_ff;
	logic w_have_ff;
	logic [ADDR_W-1:0] waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic do_write;
	logic rd_take;
	logic rd_irq_clear;
	logic mode_spd;
	logic stop_mask;
	logic [1:0] speed_sel;
	logic alarm_clear_ok;

	// Byte-lane merge of a write into a register image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Address decode shared by reads and writes
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return a == CTRL_OFS || a == STATUS_OFS || a == SPEED1_OFS || a == SPEED2_OFS ||
			a == SPEED3_OFS || a == SPEED4_OFS || a == IRQ_STATUS_OFS || a == IRQ_MASK_OFS;
	endfunction

	scil_debounce #(
		.W(IN_W),
		.CYC(DEBOUNCE_CYC)
	) u_debounce (
		.clk(aclk),
		.rst_n(aresetn),
		.raw({pulse_inhibit_in, speed_sel0, cw_stop_n, ccw_stop_n, alarm_clear_in, servo_enable_in}),
		.clean_ff(in_ff)
	);

	assign mode_spd = ctrl_ff[CTRL_MODE_BIT] == SCIL_MODE_SPD;
	assign stop_mask = ctrl_ff[CTRL_STOP_MASK_BIT];
	assign speed_sel = {in_ff[IN_INH], in_ff[IN_SEL0]};

	scil_speed_sel #(
		.SW(SPEED_W)
	) u_speed_sel (
		.clk(aclk),
		.rst_n(aresetn),
		.en(mode_spd),
		.sel(speed_sel),
		.speed1(speed1_ff),
		.speed2(speed2_ff),
		.speed3(speed3_ff),
		.speed4(speed4_ff),
		.speed_cmd_ff(speed_cmd)
	);

	// Drive enable and direction permits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_enable_ff <= 1'b0;
			ccw_permit_ff <= 1'b0;
			cw_permit_ff <= 1'b0;
		end else begin
			drive_enable_ff <= in_ff[IN_SON] && !alarm_ff;
			ccw_permit_ff <= stop_mask || in_ff[IN_CCW];
			cw_permit_ff <= stop_mask || in_ff[IN_CW];
		end
	end

	// Mode-specific decoding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dev_clear_ff <= 1'b0;
			pulse_accept_ff <= 1'b0;
			speed_valid_ff <= 1'b0;
		end else begin
			dev_clear_ff <= !mode_spd && in_ff[IN_SEL0];
			pulse_accept_ff <= !mode_spd && !in_ff[IN_INH];
			speed_valid_ff <= mode_spd;
		end
	end

	// Alarm latch; a new fault wins over a clear in the same cycle
	assign alarm_clear_ok = in_ff[IN_ALARM_CLEAR_IN] && alarm_code_ff <= ALARM_CLEARABLE_MAX;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_ff <= 1'b0;
			alarm_code_ff <= '0;
		end else if (fault_valid && (!alarm_ff || alarm_clear_ok)) begin
			alarm_ff <= 1'b1;
			alarm_code_ff <= fault_code;
		end else if (alarm_ff && alarm_clear_ok) begin
			alarm_ff <= 1'b0;
			alarm_code_ff <= '0;
		end
	end

	// Interrupt events, sticky until a read of the interrupt status register
	assign ev_now[EV_ALARM] = fault_valid && (!alarm_ff || alarm_clear_ok);
	assign ev_now[EV_ENABLE] = in_ff[IN_SON] && !alarm_ff && !drive_enable_ff;
	assign ev_now[EV_CCW_STOP] = ccw_permit_ff && !(stop_mask || in_ff[IN_CCW]);
	assign ev_now[EV_CW_STOP] = cw_permit_ff && !(stop_mask || in_ff[IN_CW]);
	assign ev_now[EV_DEV_CLEAR] = !dev_clear_ff && !mode_spd && in_ff[IN_SEL0];
	assign rd_irq_clear = rd_take && s_axi_araddr == IRQ_STATUS_OFS;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_ff <= EV_RST;
		end else if (rd_irq_clear) begin
			irq_status_ff <= ev_now;
		end else begin
			irq_status_ff <= irq_status_ff | ev_now;
		end
	end
	assign irq = |(irq_status_ff & irq_mask_ff);

	// Write channel: address and data taken in either order
	assign s_axi_awready = wstate_ff == SCIL_WS_IDLE && !aw_have_ff;
	assign s_axi_wready = wstate_ff == SCIL_WS_IDLE && !w_have_ff;
	assign do_write = wstate_ff == SCIL_WS_IDLE && aw_have_ff && w_have_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_ff <= SCIL_WS_IDLE;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			waddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			unique case (wstate_ff)
				SCIL_WS_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_have_ff <= 1'b1;
						waddr_ff <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_have_ff <= 1'b1;
						wdata_ff <= s_axi_wdata;
						wstrb_ff <= s_axi_wstrb;
					end
					if (do_write) begin
						aw_have_ff <= 1'b0;
						w_have_ff <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
						wstate_ff <= SCIL_WS_RESP;
					end
				end
				SCIL_WS_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wstate_ff <= SCIL_WS_IDLE;
					end
				end
			endcase
		end
	end

	// Software-written registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= CTRL_RST;
			speed1_ff <= SPEED_RST;
			speed2_ff <= SPEED_RST;
			speed3_ff <= SPEED_RST;
			speed4_ff <= SPEED_RST;
			irq_mask_ff <= EV_RST;
		end else if (do_write) begin
			unique case (waddr_ff)
				CTRL_OFS: ctrl_ff <= CTRL_W'(merge(32'(ctrl_ff), wdata_ff, wstrb_ff));
				SPEED1_OFS: speed1_ff <= SPEED_W'(merge(32'(speed1_ff), wdata_ff, wstrb_ff));
				SPEED2_OFS: speed2_ff <= SPEED_W'(merge(32'(speed2_ff), wdata_ff, wstrb_ff));
				SPEED3_OFS: speed3_ff <= SPEED_W'(merge(32'(speed3_ff), wdata_ff, wstrb_ff));
				SPEED4_OFS: speed4_ff <= SPEED_W'(merge(32'(speed4_ff), wdata_ff, wstrb_ff));
				IRQ_MASK_OFS: irq_mask_ff <= EV_W'(merge(32'(irq_mask_ff), wdata_ff, wstrb_ff));
				default: ;
			endcase
		end
	end

	// Read channel: data captured when the address is taken
	assign s_axi_arready = rstate_ff == SCIL_RS_IDLE;
	assign rd_take = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rstate_ff <= SCIL_RS_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			unique case (rstate_ff)
				SCIL_RS_IDLE: begin
					if (rd_take) begin
						s_axi_rvalid <= 1'b1;
						s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
						unique case (s_axi_araddr)
							CTRL_OFS: s_axi_rdata <= 32'(ctrl_ff);
							STATUS_OFS: s_axi_rdata <= 32'({alarm_code_ff, alarm_ff, speed_valid_ff,
								pulse_accept_ff, dev_clear_ff, cw_permit_ff, ccw_permit_ff, drive_enable_ff, in_ff});
							SPEED1_OFS: s_axi_rdata <= 32'(speed1_ff);
							SPEED2_OFS: s_axi_rdata <= 32'(speed2_ff);
							SPEED3_OFS: s_axi_rdata <= 32'(speed3_ff);
							SPEED4_OFS: s_axi_rdata <= 32'(speed4_ff);
							IRQ_STATUS_OFS: s_axi_rdata <= 32'(irq_status_ff);
							IRQ_MASK_OFS: s_axi_rdata <= 32'(irq_mask_ff);
							default: s_axi_rdata <= '0;
						endcase
						rstate_ff <= SCIL_RS_DATA;
					end
				end
				SCIL_RS_DATA: begin
					if (s_axi_rready) begin
						s_axi_rvalid <= 1'b0;
						rstate_ff <= SCIL_RS_IDLE;
					end
				end
			endcase
		end
	end

	enable_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!in_ff[IN_SON] |=> !drive_enable_ff)
		else $error("drive stayed enabled with servo enable off");
	enable_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		in_ff[IN_SON] && !alarm_ff ##1 in_ff[IN_SON] && !alarm_ff |-> drive_enable_ff)
		else $error("drive not enabled with servo enable on");
	alarm_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_ff && in_ff[IN_ALARM_CLEAR_IN] && alarm_code_ff <= ALARM_CLEARABLE_MAX && !fault_valid |=> !alarm_ff)
		else $error("clearable alarm not cleared");
	alarm_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_ff && !in_ff[IN_ALARM_CLEAR_IN] |=> alarm_ff && $stable(alarm_code_ff))
		else $error("alarm changed without a clear");
	alarm_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
		alarm_ff && alarm_code_ff > ALARM_CLEARABLE_MAX |=> alarm_ff && $stable(alarm_code_ff))
		else $error("high alarm code was cleared");
	ccw_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!stop_mask && !in_ff[IN_CCW] |=> !ccw_permit_ff)
		else $error("ccw drive permitted with stop input off");
	cw_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!stop_mask && !in_ff[IN_CW] |=> !cw_permit_ff)
		else $error("cw drive permitted with stop input off");
	stop_masked_a: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_mask [*2] |-> ccw_permit_ff && cw_permit_ff)
		else $error("masked stop inputs still blocked drive");
	dev_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!mode_spd && in_ff[IN_SEL0] |=> dev_clear_ff)
		else $error("deviation clear not raised in position mode");
	mode_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_spd |=> !dev_clear_ff && !pulse_accept_ff && speed_valid_ff)
		else $error("position inputs active in speed mode");
	speed_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_spd && speed_sel == 2'h2 |=> speed_cmd == $past(speed3_ff))
		else $error("wrong internal speed for select value two");
	speed_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
		mode_spd && speed_sel == 2'h3 |=> speed_cmd == $past(speed4_ff))
		else $error("internal speed four not taken from its register");
	inhibit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!mode_spd && !in_ff[IN_INH] |=> pulse_accept_ff)
		else $error("pulses refused with inhibit off");
endmodule

// *** verif/scil_ctrl_model.sv ***
// Motion controller model driving the isolated control inputs.
// Assumes the input order of the debounced vector in scil_pkg.
`timescale 1ns/10ps
module scil_ctrl_model #(
	parameter int SETTLE_CYC = 16
) (
	input wire logic aclk,
	input wire logic [5:0] want,
	output logic [5:0] pins
);
	import scil_pkg::*;
	int hold = 0;
	initial pins = 6'h00;
	always @(posedge aclk) begin
		if (hold > 0) begin
			hold <= hold - 1;
		end
		// Enable raised alone with no motion pending
		if (want[IN_SON] && !pins[IN_SON]) begin
			pins[IN_SON] <= 1'b1;
			hold <= SETTLE_CYC;
		end else if (hold == 0) begin
			pins <= want;
		end
	end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the servo control input logic.
// Assumes scil_pkg, scil_top and the controller model; registers over AXI4-Lite.
`timescale 1ns/10ps
module testbench;
	import scil_pkg::*;
	localparam int SETTLE = 16;
	localparam int WAIT = DEBOUNCE_CYC + SETTLE + 8;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, we;
	logic fault_valid = 1'b0;
	logic [ALARM_CODE_W-1:0] fault_code = '0, alarm_code_ff;
	logic drive_enable_ff, ccw_permit_ff, cw_permit_ff, dev_clear_ff, pulse_accept_ff, speed_valid_ff, alarm_ff, irq;
	logic [SPEED_W-1:0] speed_cmd;
	logic [5:0] want = '0, pins;
	logic [33:0] re;
	logic [33:0] rd_q[$];
	logic [1:0] wr_q[$];
	logic [15:0] spd[4];
	int mismatches = 0, comparisons = 0, cycles = 0;
	integer seed = 32'h1ca71d83;

	scil_ctrl_model #(.SETTLE_CYC(SETTLE)) u_ctrl (.aclk, .want, .pins);
	scil_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .servo_enable_in(pins[IN_SON]), .alarm_clear_in(pins[IN_ALARM_CLEAR_IN]),
		.ccw_stop_n(pins[IN_CCW]), .cw_stop_n(pins[IN_CW]), .speed_sel0(pins[IN_SEL0]),
		.pulse_inhibit_in(pins[IN_INH]), .fault_valid, .fault_code, .drive_enable_ff, .ccw_permit_ff,
		.cw_permit_ff, .dev_clear_ff, .pulse_accept_ff, .speed_valid_ff, .speed_cmd, .alarm_ff, .alarm_code_ff, .irq);

	initial begin
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
		wr_q.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		rd_q.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Pin change, then wait out sync, debounce and output register
	task automatic pin(input logic [5:0] w);
		want <= w;
		repeat (WAIT) @(posedge aclk);
	endtask

	task automatic fault(input logic [4:0] c);
		fault_valid <= 1'b1;
		fault_code <= c;
		@(posedge aclk);
		fault_valid <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask

	// Result watcher: oldest note against each bus answer
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			re = rd_q.pop_front();
			chk("rdata", re[31:0], s_axi_rdata);
			chk("rresp", {30'h0, re[33:32]}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid && s_axi_bready) begin
			we = wr_q.pop_front();
			chk("bresp", {30'h0, we}, {30'h0, s_axi_bresp});
		end
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			test_done();
		end
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(CTRL_OFS, 32'h0);
		rd(SPEED1_OFS, 32'h0);
		rd(IRQ_MASK_OFS, 32'h0);
		rd(STATUS_OFS, 32'h400);
		rd(6'h20, 32'h0, RESP_SLVERR);
		wr(6'h20, 32'h3, RESP_SLVERR);
		wr(STATUS_OFS, 32'hffff, RESP_OKAY);
		rd(CTRL_OFS, 32'h0);
		$display("Test map done");
		pin(6'h0d);
		rd(STATUS_OFS, 32'h5cd);
		rd(IRQ_STATUS_OFS, 32'h2);
		rd(IRQ_STATUS_OFS, 32'h0);
		$display("Test enable done");
		wr(IRQ_MASK_OFS, 32'hc, RESP_OKAY);
		pin(6'h01);
		rd(STATUS_OFS, 32'h441);
		chk("irq", 32'h1, {31'h0, irq});
		rd(IRQ_STATUS_OFS, 32'hc);
		chk("irq", 32'h0, {31'h0, irq});
		wr(CTRL_OFS, 32'h2, RESP_OKAY);
		repeat (2) @(posedge aclk);
		rd(STATUS_OFS, 32'h5c1);
		pin(6'h0d);
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		$display("Test stops done");
		wr(IRQ_MASK_OFS, 32'h10, RESP_OKAY);
		pin(6'h3d);
		rd(STATUS_OFS, 32'h3fd);
		chk("outs", 32'h3c, {26'h0, drive_enable_ff, ccw_permit_ff, cw_permit_ff, dev_clear_ff, pulse_accept_ff,
			speed_valid_ff});
		chk("irq", 32'h1, {31'h0, irq});
		rd(IRQ_STATUS_OFS, 32'h10);
		$display("Test position done");
		for (int i = 0; i < 4; i++) begin
			spd[i] = 16'($random(seed));
			wr(SPEED1_OFS + 6'(4 * i), {16'h0, spd[i]}, RESP_OKAY);
		end
		wr(CTRL_OFS, 32'h1, RESP_OKAY);
		for (int s = 0; s < 4; s++) begin
			pin({s[1:0], 4'hd});
			chk("speed_cmd", {16'h0, spd[s]}, {16'h0, speed_cmd});
			chk("mode_outs", 32'h1, {29'h0, dev_clear_ff, pulse_accept_ff, speed_valid_ff});
			rd(STATUS_OFS, 32'h9cd | 32'(s << 4));
		end
		pin(6'h0d);
		wr(CTRL_OFS, 32'h0, RESP_OKAY);
		$display("Test speed done");
		fault(5'h05);
		rd(STATUS_OFS, 32'hb58d);
		pin(6'h0f);
		rd(STATUS_OFS, 32'h5cf);
		fault(5'h09);
		pin(6'h0d);
		pin(6'h0f);
		rd(STATUS_OFS, 32'h1358f);
		chk("alarm_code", 32'h9, {27'h0, alarm_code_ff});
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("alarm", 32'h0, {31'h0, alarm_ff});
		chk("drive_enable", 32'h0, {31'h0, drive_enable_ff});
		$display("Test alarm done");
		test_done();
	end
endmodule
